// ===== hw/event_sel.sv
`timescale 1ns/10ps
// picks one event line for a counter; code zero means hold
module event_sel #(
   parameter int N_EV = 128,
   parameter int SW   = 7
) (
   input  wire logic [N_EV-1:0] i_events,
   input  wire logic [SW-1:0]   i_sel,
   output logic                 o_hit
);
   // hold code selects line 0, which the top ties low
   assign o_hit = i_events[i_sel];
endmodule

// ===== hw/ovf_irq.sv
`timescale 1ns/10ps
// forms the interrupt condition from the counter top bits
module ovf_irq (
   input  wire logic       i_gie,
   input  wire logic       i_c1_ie,
   input  wire logic       i_c234_ie,
   input  wire logic [3:0] i_top,
   output logic            o_irq
);
   // both per-counter and global enables needed [RQ16] [RQ2] [RQ3] [RQ15]
   assign o_irq = i_gie & ((i_c1_ie & i_top[0]) | (i_c234_ie & (|i_top[3:1])));
endmodule

// ===== hw/perf_monitor.sv
`timescale 1ns/10ps
// performance monitor control registers and four event counters
module perf_monitor
   import perf_monitor_pkg::*;
#(
   parameter int N_EV1 = 128,
   parameter int N_EV2 = 64,
   parameter int N_EV3 = 32,
   parameter int N_EV4 = 32
) (
   input  wire logic             i_ref_clk,
   input  wire logic             i_nrst,
   input  wire logic             i_spr_wr,
   input  wire logic             i_spr_rd,
   input  wire logic [9:0]       i_spr_num,
   input  wire logic [31:0]      i_spr_wdata,
   input  wire logic [N_EV1-1:0] i_ev1,
   input  wire logic [N_EV2-1:0] i_ev2,
   input  wire logic [N_EV3-1:0] i_ev3,
   input  wire logic [N_EV4-1:0] i_ev4,
   output logic [31:0]           o_spr_rdata,
   output logic                  o_spr_ack,
   output logic                  o_pm_irq,
   output logic [5:0]            o_threshold
);
   import perf_monitor_pkg::*;

   typedef struct packed {
      logic [31:0]      ctrl_a;
      logic [31:0]      ctrl_b;
      logic [3:0][31:0] cnt;
      logic             frozen;
      logic             released;
      logic [31:0]      rdata;
      logic             ack;
      logic             irq;
   } state_t;

   state_t st_r;
   state_t st_nxt;
   logic [3:0] hit;
   logic [3:0] top;
   logic       irq_cond;

   // true when a special-register access hits one of our numbers
   function automatic logic is_ours(input logic [9:0] n);
      is_ours = (n == SPR_CTRL_A) || (n == SPR_CTRL_B) || (n == SPR_USR_CTRL_A) ||
                (n == SPR_USR_CTRL_B) || (n == SPR_CNT_1) || (n == SPR_CNT_2) ||
                (n == SPR_CNT_3) || (n == SPR_CNT_4);
   endfunction

   // event selection per counter; line 0 is the hold code so it is forced low
   event_sel #(.N_EV(N_EV1), .SW(7)) u_sel1 (
      .i_events ({i_ev1[N_EV1-1:1], 1'b0}),
      .i_sel    (st_r.ctrl_a[A_SEL1_LSB +: 7]), // [RQ6]
      .o_hit    (hit[0])
   );
   event_sel #(.N_EV(N_EV2), .SW(6)) u_sel2 (
      .i_events ({i_ev2[N_EV2-1:1], 1'b0}),
      .i_sel    (st_r.ctrl_a[A_SEL2_LSB +: 6]), // [RQ7]
      .o_hit    (hit[1])
   );
   event_sel #(.N_EV(N_EV3), .SW(5)) u_sel3 (
      .i_events ({i_ev3[N_EV3-1:1], 1'b0}),
      .i_sel    (st_r.ctrl_b[B_SEL3_LSB +: 5]), // [RQ10]
      .o_hit    (hit[2])
   );
   event_sel #(.N_EV(N_EV4), .SW(5)) u_sel4 (
      .i_events ({i_ev4[N_EV4-1:1], 1'b0}),
      .i_sel    (st_r.ctrl_b[B_SEL4_LSB +: 5]), // [RQ11]
      .o_hit    (hit[3])
   );

   // overflow flags are the counter top bits
   always_comb begin
      for (int k = 0; k < N_CNT; k++) begin
         top[k] = st_r.cnt[k][TOP_BIT]; // [RQ15]
      end
   end

   ovf_irq u_irq (
      .i_gie     (st_r.ctrl_a[A_GIE_POS]),
      .i_c1_ie   (st_r.ctrl_a[A_C1_IE_POS]),
      .i_c234_ie (st_r.ctrl_a[A_C234_IE_POS]),
      .i_top     (top),
      .o_irq     (irq_cond)
   );

   // next-state logic: counting, interrupt, register access
   always_comb begin
      logic run1;
      logic run234;
      run1   = 1'b0;
      run234 = 1'b0;
      st_nxt = st_r;
      st_nxt.ack   = 1'b0;
      st_nxt.irq   = 1'b0;
      st_nxt.rdata = 32'h0000_0000;

      // freeze only applies to counter one when the 2-4 enable is set
      run1   = ~(st_r.frozen & st_r.ctrl_a[A_FREEZE_POS]); // [RQ18]
      run234 = ~(st_r.frozen & st_r.ctrl_a[A_FREEZE_POS] &
                 ~st_r.ctrl_a[A_C234_IE_POS]); // [RQ4]
      // start hold for counters two to four
      if (st_r.ctrl_a[A_HOLD_POS] && !st_r.released) begin
         run234 = 1'b0; // [RQ5]
      end
      if (run1 && hit[0]) begin
         st_nxt.cnt[0] = st_r.cnt[0] + 32'h0000_0001; // [RQ14]
      end
      for (int k = 1; k < N_CNT; k++) begin
         if (run234 && hit[k]) begin
            st_nxt.cnt[k] = st_r.cnt[k] + 32'h0000_0001; // [RQ14]
         end
      end
      if (top[0]) begin
         st_nxt.released = 1'b1; // [RQ5]
      end
      // signalling drops the global enable and may freeze counting
      if (irq_cond) begin
         st_nxt.irq = 1'b1;
         st_nxt.ctrl_a[A_GIE_POS] = 1'b0; // [RQ17]
         st_nxt.frozen   = 1'b1; // [RQ18]
         st_nxt.released = 1'b1; // [RQ5]
      end
      // writes win over counting in the same cycle; the global enable write wins too
      if (i_spr_wr) begin
         case (i_spr_num)
            SPR_CTRL_A: begin
               st_nxt.ctrl_a   = i_spr_wdata; // [RQ8] [RQ1]
               // a write re-arms both latches, but an event in the same cycle still sets them
               st_nxt.frozen   = irq_cond; // [RQ18]
               st_nxt.released = top[0] | irq_cond; // [RQ5]
            end
            SPR_CTRL_B: st_nxt.ctrl_b = i_spr_wdata & B_WRITE_MASK; // [RQ12] [RQ19]
            SPR_CNT_1:  st_nxt.cnt[0] = i_spr_wdata;
            SPR_CNT_2:  st_nxt.cnt[1] = i_spr_wdata;
            SPR_CNT_3:  st_nxt.cnt[2] = i_spr_wdata;
            SPR_CNT_4:  st_nxt.cnt[3] = i_spr_wdata;
            default: ; // mirrors and foreign numbers ignore writes [RQ9] [RQ13]
         endcase
         st_nxt.ack = is_ours(i_spr_num);
      end else if (i_spr_rd) begin
         case (i_spr_num)
            SPR_CTRL_A:     st_nxt.rdata = st_r.ctrl_a; // [RQ8]
            SPR_USR_CTRL_A: st_nxt.rdata = st_r.ctrl_a; // [RQ9]
            SPR_CTRL_B:     st_nxt.rdata = st_r.ctrl_b; // [RQ12]
            SPR_USR_CTRL_B: st_nxt.rdata = st_r.ctrl_b; // [RQ13]
            SPR_CNT_1:      st_nxt.rdata = st_r.cnt[0];
            SPR_CNT_2:      st_nxt.rdata = st_r.cnt[1];
            SPR_CNT_3:      st_nxt.rdata = st_r.cnt[2];
            SPR_CNT_4:      st_nxt.rdata = st_r.cnt[3];
            default:        st_nxt.rdata = 32'h0000_0000;
         endcase
         st_nxt.ack = is_ours(i_spr_num);
      end
   end

   // single state register; control cleared at power up
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_r.ctrl_a   <= CTRL_RESET;
         st_r.ctrl_b   <= CTRL_RESET;
         st_r.cnt      <= {N_CNT{CNT_RESET}};
         st_r.frozen   <= 1'b0;
         st_r.released <= 1'b0;
         st_r.rdata    <= 32'h0000_0000;
         st_r.ack      <= 1'b0;
         st_r.irq      <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_spr_rdata = st_r.rdata;
   assign o_spr_ack   = st_r.ack;
   assign o_pm_irq    = st_r.irq;
   assign o_threshold = st_r.ctrl_a[A_THRESH_LSB +: 6]; // [RQ1]
endmodule

// ===== hw/perf_monitor_pkg.sv
// Notes on behaviour
// RQ1: control A bits 10..15 hold a six-bit miss-latency threshold, any value 0..63.
// RQ2: control A bit 16 lets counter one overflow signal an interrupt.
// RQ3: control A bit 17 lets counters two to four overflow signal an interrupt.
// RQ4: bit 17 enable takes precedence over freeze-on-interrupt for counters two to four.
// RQ5: bit 18 holds counters two to four until counter one top bit or interrupt.
// RQ6: control A bits 19..25 select counter one event, 128 choices.
// RQ7: control A bits 26..31 select counter two event, 64 choices.
// RQ8: control A is read and written at special register 952.
// RQ9: control A mirrored read-only to user at special register 936.
// RQ10: control B bits 0..4 select counter three event, 32 choices.
// RQ11: control B bits 5..9 select counter four event; bits 10..31 reserved.
// RQ12: control B is read and written at special register 956.
// RQ13: control B mirrored read-only to user at special register 940.
// RQ14: four 32-bit counters, each may raise an interrupt on overflow.
// RQ15: a counter has overflowed once its top bit is set.
// RQ16: overflow signals only when its enable and global enable are both set.
// RQ17: hardware clears global enable (bit 5) when an interrupt is signalled; a control A write in that cycle keeps its written value instead.
// RQ18: with freeze-on-interrupt set, counters stop once a counter interrupt occurs.
// RQ19: reserved bits of control B read zero and ignore writes.
package perf_monitor_pkg;
   localparam logic [9:0] SPR_CTRL_A     = 10'h3B8;
   localparam logic [9:0] SPR_CTRL_B     = 10'h3BC;
   localparam logic [9:0] SPR_USR_CTRL_A = 10'h3A8;
   localparam logic [9:0] SPR_USR_CTRL_B = 10'h3AC;
   localparam logic [9:0] SPR_CNT_1      = 10'h3B9;
   localparam logic [9:0] SPR_CNT_2      = 10'h3BA;
   localparam logic [9:0] SPR_CNT_3      = 10'h3BD;
   localparam logic [9:0] SPR_CNT_4      = 10'h3BE;
   localparam int  N_CNT            = 4;
   localparam int  CNT_W            = 32;
   localparam int  TOP_BIT          = 31;
   // control A and B field positions, lsb-numbered (documented bit k sits at 31-k)
   localparam int  A_FREEZE_POS     = 25;
   localparam int  A_GIE_POS        = 26;
   localparam int  A_THRESH_LSB     = 16;
   localparam int  A_C1_IE_POS      = 15;
   localparam int  A_C234_IE_POS    = 14;
   localparam int  A_HOLD_POS       = 13;
   localparam int  A_SEL1_LSB       = 6;
   localparam int  A_SEL2_LSB       = 0;
   localparam int  B_SEL3_LSB       = 27;
   localparam int  B_SEL4_LSB       = 22;
   localparam logic [31:0] B_WRITE_MASK = 32'hFFC0_0000;
   localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
   localparam logic [31:0] CNT_RESET    = 32'h0000_0000;
   localparam logic [6:0]  SEL_HOLD     = 7'h00;
endpackage

// ===== verif/perf_monitor_chk.sv
`timescale 1ns/10ps
// port-level checks on the access handshake, interrupt pulse and threshold field
module perf_monitor_chk (
   input  wire logic        i_ref_clk,
   input  wire logic        i_nrst,
   input  wire logic        i_spr_wr,
   input  wire logic        i_spr_rd,
   input  wire logic [9:0]  i_spr_num,
   input  wire logic [31:0] i_spr_wdata,
   input  wire logic [31:0] o_spr_rdata,
   input  wire logic        o_spr_ack,
   input  wire logic        o_pm_irq,
   input  wire logic [5:0]  o_threshold
);
   logic req;
   logic mapped;
   // only the eight mapped numbers may answer, so a stray ack is caught
   assign req    = i_spr_wr | i_spr_rd;
   assign mapped = i_spr_num inside {10'h3B8, 10'h3BC, 10'h3A8, 10'h3AC,
                                     10'h3B9, 10'h3BA, 10'h3BD, 10'h3BE};
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_nrst);
   sequence s_wr_a;
      i_spr_wr && i_spr_num == 10'h3B8;
   endsequence
   sequence s_rd_a;
      i_spr_rd && !i_spr_wr && i_spr_num inside {10'h3A8, 10'h3B8};
   endsequence
   sequence s_rd_b;
      i_spr_rd && !i_spr_wr && i_spr_num inside {10'h3BC, 10'h3AC};
   endsequence
   a_mapped_ack: assert property (req && mapped |=> o_spr_ack)
      else $error("mapped access not acknowledged");
   a_stray_ack: assert property (!(req && mapped) |=> !o_spr_ack)
      else $error("ack without a mapped access");
   a_rdata_idle: assert property (!o_spr_ack |-> o_spr_rdata == 32'h0)
      else $error("read data not zero outside ack");
   a_thresh_load: assert property (s_wr_a |=> o_threshold == $past(i_spr_wdata[21:16]))
      else $error("threshold not loaded from write");
   a_thresh_keep: assert property (!(i_spr_wr && i_spr_num == 10'h3B8)
      |=> $stable(o_threshold))
      else $error("threshold moved without a write");
   a_resv_zero: assert property (s_rd_b |=> o_spr_rdata[21:0] == 22'h0)
      else $error("reserved control b bits not zero");
   a_mirror_thr: assert property (s_rd_a
      |=> o_spr_rdata[21:16] == $past(o_threshold))
      else $error("control a read disagrees with threshold");
   a_irq_pulse: assert property (o_pm_irq |=> !o_pm_irq)
      else $error("interrupt longer than one cycle");
endmodule

// ===== verif/perf_monitor_tb.sv
`timescale 1ns/10ps
// directed bench for the monitor control registers and counters
module perf_monitor_tb;
   import perf_monitor_pkg::*;
   logic         i_ref_clk = 1'b0, i_nrst = 1'b0, i_spr_wr = 1'b0, i_spr_rd = 1'b0;
   logic [9:0]   i_spr_num = 10'h000;
   logic [31:0]  i_spr_wdata = 32'h0, i_ev3 = 32'h0, i_ev4 = 32'h0, o_spr_rdata, q, p;
   logic [127:0] i_ev1 = 128'h0;
   logic [63:0]  i_ev2 = 64'h0;
   logic         o_spr_ack, o_pm_irq, a;
   logic [5:0]   o_threshold;
   int           failures = 0, tests_run = 0, irqs = 0;
   always #2 i_ref_clk = ~i_ref_clk;
   perf_monitor u_perf_monitor (.i_ref_clk, .i_nrst, .i_spr_wr, .i_spr_rd, .i_spr_num,
      .i_spr_wdata, .i_ev1, .i_ev2, .i_ev3, .i_ev4, .o_spr_rdata, .o_spr_ack, .o_pm_irq,
      .o_threshold);
   // interrupt is a one-cycle pulse, so count it at every edge rather than poll
   always @(posedge i_ref_clk) if (o_pm_irq === 1'b1) irqs++;
   task chk(input logic [31:0] g, input logic [31:0] e, input string m);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("Error at %0t: %s", $time, m);
      end
   endtask
   // one register access; ack and data caught in the cycle they stand
   task spr(input logic w, input logic [9:0] n, input logic [31:0] d);
      a = 1'b0;
      q = 'x;
      @(posedge i_ref_clk);
      i_spr_wr <= w;
      i_spr_rd <= !w;
      i_spr_num <= n;
      i_spr_wdata <= d;
      @(posedge i_ref_clk);
      i_spr_wr <= 1'b0;
      i_spr_rd <= 1'b0;
      repeat (3) begin
         #1;
         if (o_spr_ack === 1'b1 && !a) begin
            a = 1'b1;
            q = o_spr_rdata;
         end
         @(posedge i_ref_clk);
      end
   endtask
   task t_regs;
      spr(1, SPR_CTRL_A, 32'h5A5A_A5A5);
      spr(0, SPR_CTRL_A, 0);
      chk(q, 32'h5A5A_A5A5, "control a readback");
      chk({26'h0, o_threshold}, 32'h1A, "threshold field");
      spr(1, SPR_USR_CTRL_A, 0);
      chk({31'h0, a}, 1, "mirror write not acked");
      spr(0, SPR_USR_CTRL_A, 0);
      chk(q, 32'h5A5A_A5A5, "control a mirror");
      spr(1, SPR_CTRL_B, 32'hFFFF_FFFF);
      spr(0, SPR_CTRL_B, 0);
      chk(q, B_WRITE_MASK, "control b readback");
      spr(0, SPR_USR_CTRL_B, 0);
      chk(q, B_WRITE_MASK, "control b mirror");
      spr(0, 10'h3FF, 0);
      chk({31'h0, a}, 0, "unmapped number acked");
      spr(1, SPR_CTRL_A, 0);
      spr(1, SPR_CTRL_B, 0);
      $display("done t_regs");
   endtask
   task t_count;
      spr(1, SPR_CNT_3, 0);
      spr(1, SPR_CTRL_B, 32'h2800_0000);
      @(posedge i_ref_clk);
      i_ev3[5] <= 1'b1;
      repeat (20) @(posedge i_ref_clk);
      i_ev3[5] <= 1'b0;
      spr(0, SPR_CNT_3, 0);
      chk(q, 32'd20, "counter three count");
      $display("done t_count");
   endtask
   task t_ovf;
      i_ev1[1] <= 1'b1;
      spr(1, SPR_CNT_1, 32'h7FFF_FFFE);
      spr(1, SPR_CTRL_A, 32'h0200_8040);
      repeat (10) @(posedge i_ref_clk);
      chk(irqs, 0, "irq without global enable");
      spr(1, SPR_CTRL_A, 32'h0600_8040);
      repeat (6) @(posedge i_ref_clk);
      chk(irqs, 1, "overflow irq count");
      spr(0, SPR_CTRL_A, 0);
      chk(q, 32'h0200_8040, "global enable not cleared");
      spr(0, SPR_CNT_1, 0);
      p = q;
      repeat (5) @(posedge i_ref_clk);
      spr(0, SPR_CNT_1, 0);
      chk(q, p, "counter one not frozen");
      i_ev1[1] <= 1'b0;
      $display("done t_ovf");
   endtask
   task t_hold;
      spr(1, SPR_CNT_1, 0);
      spr(1, SPR_CNT_2, 0);
      i_ev2[2] <= 1'b1;
      spr(1, SPR_CTRL_A, 32'h0000_2002);
      repeat (8) @(posedge i_ref_clk);
      spr(0, SPR_CNT_2, 0);
      chk(q, 0, "counter two counted while held");
      spr(1, SPR_CNT_1, 32'h8000_0000);
      repeat (8) @(posedge i_ref_clk);
      spr(0, SPR_CNT_2, 0);
      // release latch sets one edge after the top bit, counting starts the edge after
      chk(q, 32'd11, "counter two not released");
      i_ev2[2] <= 1'b0;
      $display("done t_hold");
   endtask
   // counter four overflow; the 2-4 enable overrides freeze, so counting goes on
   task t_c234;
      spr(1, SPR_CTRL_A, 0);
      spr(1, SPR_CNT_4, 32'h7FFF_FFF0);
      i_ev4[3] <= 1'b1;
      spr(1, SPR_CTRL_B, 32'h00C0_0000);
      repeat (20) @(posedge i_ref_clk);
      spr(1, SPR_CTRL_A, 32'h0600_4000);
      repeat (6) @(posedge i_ref_clk);
      chk(irqs, 2, "counter four overflow irq count");
      spr(0, SPR_CTRL_A, 0);
      chk(q, 32'h0200_4000, "global enable not cleared by 2-4 irq");
      spr(0, SPR_CNT_4, 0);
      p = q;
      repeat (5) @(posedge i_ref_clk);
      spr(0, SPR_CNT_4, 0);
      chk(q, p + 32'd10, "counter four frozen despite 2-4 enable");
      i_ev4[3] <= 1'b0;
      $display("done t_c234");
   endtask
   task finish_test;
      $display("comparisons %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge i_ref_clk);
      i_nrst <= 1'b1;
      t_regs;
      t_count;
      t_ovf;
      t_hold;
      t_c234;
      finish_test;
   end
   // the whole run is a few hundred cycles; this cuts a hang short
   initial begin
      #40000;
      failures++;
      finish_test;
   end
endmodule
bind perf_monitor perf_monitor_chk u_perf_monitor_chk (.i_ref_clk, .i_nrst, .i_spr_wr,
   .i_spr_rd, .i_spr_num, .i_spr_wdata, .o_spr_rdata, .o_spr_ack, .o_pm_irq, .o_threshold);
